/* File: srt_pkg.sv */
package srt_pkg;

  // Core clock and millisecond tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int MS_CYCLES     = NS_PER_MS / CLK_PERIOD_NS;
  localparam int TICK_W        = 17;

  // Millisecond timer width, enough for the longest data valid window
  localparam int TW = 19;

  // Sequencer times in milliseconds; each tick is one millisecond
  localparam logic [TW-1:0] T_INIT_MS        = 19'h00104; // 260 ms
  localparam logic [TW-1:0] T_ENTRY_3S_MS    = 19'h00258; // 600 ms
  localparam logic [TW-1:0] T_ENTRY_LONG_MS  = 19'h00a28; // 2600 ms
  localparam logic [TW-1:0] T_STBY_RET_MS    = 19'h0000b; // 11 ms
  localparam logic [TW-1:0] T_VALID_3S_MS    = 19'h00b86; // 2950 ms
  localparam logic [TW-1:0] T_VALID_100S_MS  = 19'h1866e; // 99950 ms
  localparam logic [TW-1:0] T_VALID_300S_MS  = 19'h493ae; // 299950 ms
  localparam logic [TW-1:0] T_UPDATE_MS      = 19'h00037; // 55 ms
  localparam logic [TW-1:0] T_MEASURE_MS     = 19'h001f9; // 505 ms
  localparam logic [TW-1:0] T_CMD_MS         = 19'h00006; // 6 ms
  localparam logic [TW-1:0] T_FILTER_MS      = 19'h0ea60; // 60000 ms

  // Cycle period codes
  localparam logic [1:0] CYC_3S   = 2'h0;
  localparam logic [1:0] CYC_100S = 2'h1;
  localparam logic [1:0] CYC_300S = 2'h2;

  // Particle sensor select values
  localparam logic [7:0] PSEL_OFF = 8'h00;
  localparam logic [7:0] PSEL_A   = 8'h01;
  localparam logic [7:0] PSEL_B   = 8'h02;

  localparam int PCNT_W = 16;

  typedef enum logic [2:0] {
    ST_INIT     = 3'h0,
    ST_STANDBY  = 3'h1,
    ST_MEASURE  = 3'h2,
    ST_TO_CYCLE = 3'h3,
    ST_CYC_VAL  = 3'h4,
    ST_CYC_UPD  = 3'h5,
    ST_TO_STBY  = 3'h6
  } srt_state_t;

endpackage

/* File: srt_ms_timer.sv */
`timescale 1ns/1ps
module srt_ms_timer (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_tick,
  input  wire logic                 i_load,
  input  wire logic [srt_pkg::TW-1:0] i_value,
  output logic                      o_done,
  output logic                      o_busy
);
  import srt_pkg::*;

  logic [TW-1:0] cnt_r;
  logic          done_r;

  wire last_tick = i_tick && (cnt_r == TW'(1));

  // Load wins over the running count so a restart is never lost
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= !i_load && last_tick;
      if (i_load) begin
        cnt_r <= i_value;
      end else if (i_tick && cnt_r != '0) begin
        cnt_r <= cnt_r - TW'(1);
      end
    end
  end

  assign o_done = done_r;
  assign o_busy = (cnt_r != '0);
endmodule

/* File: srt_sequencer.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - After power-on or reset command, ready asserts in standby within 260 ms.
// - Cycle entry ignores bus; first ready within 0.6 s or 2.6 s by period.
// - Standby command in cycle mode ignores bus; ready within 11.0 ms.
// - Ready stays asserted 2.95, 99.95 or 299.95 s per cycle.
// - Ready deasserts at most 55 ms per cycle; host must not read then.
// - On-demand measurement ignores bus; ready returns within 505 ms.
// - Any other write command completes within 6 ms of its start.
// - Sound alert asserts within 40 ms of amplitude exceeding threshold.
// - Light alert asserts within 100 ms of illuminance crossing threshold.
// - Clear command deasserts the matching alert within 10 ms.
// - Particle monitoring is disabled after every reset or power-on.
// - Writing 1 or 2 to particle select enables monitoring of that type; the code takes it only while select is 0.
// - Particle filter restarts on each select change, settles in about a minute.
// - Alert lines drive 0 V when asserted, released to pull-up otherwise.
// - Sound and light alerts work in both standby and cycle mode.
// - Ready drives 0 V when ready, released to pull-up when not.
// - Cycle period is 3, 100 or 300 s, chosen in standby before entry.
// - Latch alerts hold until cleared; comparator alerts follow the level.
module srt_sequencer #(
  parameter int P_MS_CYCLES = srt_pkg::MS_CYCLES
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_cmd_reset,
  input  wire logic                      i_cmd_measure,
  input  wire logic                      i_cmd_cycle,
  input  wire logic                      i_cmd_standby,
  input  wire logic                      i_cmd_clr_sound,
  input  wire logic                      i_cmd_clr_light,
  input  wire logic                      i_wr_start,
  input  wire logic [1:0]                i_cycle_sel,
  input  wire logic                      i_particle_wr,
  input  wire logic [7:0]                i_particle_sel,
  input  wire logic                      i_sound_en,
  input  wire logic                      i_sound_cmp,
  input  wire logic                      i_sound_over,
  input  wire logic                      i_light_en,
  input  wire logic                      i_light_cmp,
  input  wire logic                      i_light_over,
  input  wire logic                      i_particle_pulse_in,
  output logic                           o_ready_oe,
  output logic                           o_sound_alert_out_oe,
  output logic                           o_light_alert_out_oe,
  output logic                           o_bus_ignore,
  output logic                           o_cmd_busy,
  output logic                           o_cycle_mode,
  output logic [7:0]                     o_particle_sel,
  output logic                           o_particle_en,
  output logic                           o_filter_settled,
  output logic [srt_pkg::PCNT_W-1:0]     o_particle_edges
);
  import srt_pkg::*;

  // Reset release through two flops; assertion stays asynchronous
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  // Millisecond enable; every time below is counted in these ticks
  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick_r;
  wire tick_wrap = (tick_cnt_r == TICK_W'(P_MS_CYCLES - 1));
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + TICK_W'(1);
      tick_r     <= tick_wrap;
    end
  end

  srt_state_t    state_r, state_nxt;
  logic [1:0]    period_r;
  logic          fsm_done;

  // Bus is deaf while initialising, measuring or switching mode
  wire bus_on   = (state_r == ST_STANDBY) || (state_r == ST_CYC_VAL) || (state_r == ST_CYC_UPD);
  wire do_reset = bus_on && i_cmd_reset;
  wire in_cycle = (state_r == ST_CYC_VAL) || (state_r == ST_CYC_UPD);

  // Time for the state being entered
  function automatic logic [TW-1:0] state_time(input srt_state_t st, input logic [1:0] per);
    logic [TW-1:0] t;
    t = '0;
    case (st)
      ST_INIT:     t = T_INIT_MS;
      ST_MEASURE:  t = T_MEASURE_MS;
      ST_TO_CYCLE: t = (per == CYC_3S) ? T_ENTRY_3S_MS : T_ENTRY_LONG_MS;
      ST_CYC_VAL:  t = (per == CYC_3S) ? T_VALID_3S_MS :
                       (per == CYC_100S) ? T_VALID_100S_MS : T_VALID_300S_MS;
      ST_CYC_UPD:  t = T_UPDATE_MS;
      ST_TO_STBY:  t = T_STBY_RET_MS;
      default:     t = '0;
    endcase
    return t;
  endfunction

  // Next state; reset command restarts initialisation from any listening state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT:     if (fsm_done) state_nxt = ST_STANDBY;
      ST_STANDBY: begin
        if (i_cmd_measure) state_nxt = ST_MEASURE;
        else if (i_cmd_cycle) state_nxt = ST_TO_CYCLE;
      end
      ST_MEASURE:  if (fsm_done) state_nxt = ST_STANDBY;
      ST_TO_CYCLE: if (fsm_done) state_nxt = ST_CYC_VAL;
      ST_CYC_VAL: begin
        if (i_cmd_standby) state_nxt = ST_TO_STBY;
        else if (fsm_done) state_nxt = ST_CYC_UPD;
      end
      ST_CYC_UPD: begin
        if (i_cmd_standby) state_nxt = ST_TO_STBY;
        else if (fsm_done) state_nxt = ST_CYC_VAL;
      end
      ST_TO_STBY:  if (fsm_done) state_nxt = ST_STANDBY;
      default:     state_nxt = ST_INIT;
    endcase
    if (do_reset) state_nxt = ST_INIT;
  end

  wire           fsm_load  = (state_nxt != state_r) || do_reset;
  // Code 3 reads as the 3 s period for the entry time and the latched period alike
  wire [1:0]     sel_norm  = (i_cycle_sel > CYC_300S) ? CYC_3S : i_cycle_sel;
  wire [TW-1:0]  fsm_value = state_time(state_nxt, (state_r == ST_STANDBY) ? sel_norm : period_r);
  logic          init_arm_r;

  // The timer is loaded on power-up too, so the first init is timed as well
  srt_ms_timer u_fsm_timer (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .i_tick     (tick_r),
    .i_load     (fsm_load || init_arm_r),
    .i_value    (init_arm_r ? T_INIT_MS : fsm_value),
    .o_done     (fsm_done),
    .o_busy     ()
  );

  // Period is latched only in standby, so a change during cycling waits
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_INIT;
      period_r   <= CYC_3S;
      init_arm_r <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      init_arm_r <= 1'b0;
      if (state_r == ST_STANDBY && i_cmd_cycle && !i_cmd_measure) period_r <= sel_norm;
    end
  end

  // Other writes: busy for the processing time from the start of the write
  logic cmd_busy;
  srt_ms_timer u_cmd_timer (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .i_tick     (tick_r),
    .i_load     (i_wr_start && bus_on),
    .i_value    (T_CMD_MS),
    .o_done     (),
    .o_busy     (cmd_busy)
  );

  // Particle select: only 0, 1, 2 accepted, and never straight between 1 and 2
  logic [7:0] psel_r;
  logic       pen_r;
  wire psel_ok  = (i_particle_sel == PSEL_OFF) || ((i_particle_sel == PSEL_A || i_particle_sel == PSEL_B) && psel_r == PSEL_OFF);
  wire psel_chg = bus_on && i_particle_wr && psel_ok && (i_particle_sel != psel_r);
  logic filt_busy;
  srt_ms_timer u_filter_timer (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .i_tick     (tick_r),
    .i_load     (psel_chg),
    .i_value    (T_FILTER_MS),
    .o_done     (),
    .o_busy     (filt_busy)
  );

  // Particle pin crosses into the core clock through two flops
  logic prt_s1_r, prt_s2_r, prt_s3_r;
  wire  prt_rise = prt_s2_r && !prt_s3_r;
  logic [PCNT_W-1:0] pedges_r;
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      psel_r   <= PSEL_OFF;
      pen_r    <= 1'b0;
      prt_s1_r <= 1'b0;
      prt_s2_r <= 1'b0;
      prt_s3_r <= 1'b0;
      pedges_r <= '0;
    end else begin
      prt_s1_r <= i_particle_pulse_in;
      prt_s2_r <= prt_s1_r;
      prt_s3_r <= prt_s2_r;
      if (do_reset) psel_r <= PSEL_OFF;
      else if (psel_chg) psel_r <= i_particle_sel;
      // Enable kept in its own flop so the output needs no decode after it
      if (do_reset) pen_r <= 1'b0;
      else if (psel_chg) pen_r <= (i_particle_sel != PSEL_OFF);
      if (psel_chg || do_reset) pedges_r <= '0;
      else if (psel_r != PSEL_OFF && prt_rise) pedges_r <= pedges_r + PCNT_W'(1);
    end
  end

  // Latch sets on the level being over threshold once armed; set beats clear
  logic snd_lat_r, lgt_lat_r;
  wire snd_set = i_sound_en && i_sound_over && !i_sound_cmp;
  wire lgt_set = i_light_en && i_light_over && !i_light_cmp;
  wire snd_clr = bus_on && i_cmd_clr_sound;
  wire lgt_clr = bus_on && i_cmd_clr_light;
  wire snd_act = i_sound_en && (i_sound_cmp ? i_sound_over : snd_lat_r);
  wire lgt_act = i_light_en && (i_light_cmp ? i_light_over : lgt_lat_r);
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      snd_lat_r <= 1'b0;
      lgt_lat_r <= 1'b0;
    end else begin
      if (snd_set) snd_lat_r <= 1'b1;
      else if (snd_clr || do_reset) snd_lat_r <= 1'b0;
      if (lgt_set) lgt_lat_r <= 1'b1;
      else if (lgt_clr || do_reset) lgt_lat_r <= 1'b0;
    end
  end

  // Registered pin drives; enable high pulls the line to 0 V
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_ready_oe           <= 1'b0;
      o_sound_alert_out_oe <= 1'b0;
      o_light_alert_out_oe <= 1'b0;
      o_bus_ignore         <= 1'b1;
      o_cmd_busy           <= 1'b0;
      o_cycle_mode         <= 1'b0;
      o_filter_settled     <= 1'b0;
    end else begin
      o_ready_oe           <= (state_r == ST_STANDBY) || (state_r == ST_CYC_VAL);
      o_sound_alert_out_oe <= snd_act;
      o_light_alert_out_oe <= lgt_act;
      o_bus_ignore         <= !bus_on;
      o_cmd_busy           <= cmd_busy;
      o_cycle_mode         <= in_cycle;
      o_filter_settled     <= (psel_r != PSEL_OFF) && !filt_busy;
    end
  end
  assign o_particle_sel   = psel_r;
  assign o_particle_en    = pen_r;
  assign o_particle_edges = pedges_r;

  // Milliseconds spent in the current state, for the checks below
  logic [TW-1:0] st_ms_r;
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) st_ms_r <= '0;
    else if (fsm_load) st_ms_r <= '0;
    else if (tick_r) st_ms_r <= st_ms_r + TW'(1);
  end

  // Milliseconds of busy time since the last write start, counted apart from the timer
  logic [TW-1:0] cmd_ms_r;
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) cmd_ms_r <= '0;
    else if (i_wr_start && bus_on) cmd_ms_r <= '0;
    else if (tick_r && cmd_busy) cmd_ms_r <= cmd_ms_r + TW'(1);
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  a_init_bound:   assert property (state_r == ST_INIT |-> st_ms_r <= T_INIT_MS) else $error("init too long");
  a_entry_bound:  assert property (state_r == ST_TO_CYCLE |-> st_ms_r <= T_ENTRY_LONG_MS) else $error("cycle entry too long");
  a_stby_bound:   assert property (state_r == ST_TO_STBY |-> st_ms_r <= T_STBY_RET_MS) else $error("standby return too long");
  a_update_bound: assert property (state_r == ST_CYC_UPD |-> st_ms_r <= T_UPDATE_MS) else $error("update window too long");
  a_meas_bound:   assert property (state_r == ST_MEASURE |-> st_ms_r <= T_MEASURE_MS) else $error("measurement too long");
  a_meas_deaf:    assert property (state_r == ST_MEASURE && i_cmd_cycle && !fsm_done |=> state_r == ST_MEASURE) else $error("command taken while busy");
  a_ready_state:  assert property (##1 o_ready_oe == ($past(state_r) == ST_STANDBY || $past(state_r) == ST_CYC_VAL)) else $error("ready mismatch");
  a_sound_cmp:    assert property (i_sound_en && i_sound_cmp && i_sound_over |=> o_sound_alert_out_oe) else $error("sound comparator late");
  a_sound_clear:  assert property (bus_on && i_cmd_clr_sound && !snd_set && !i_sound_cmp |-> ##[1:2] !o_sound_alert_out_oe) else $error("sound clear late");
  a_light_hold:   assert property (lgt_lat_r && !lgt_clr && !do_reset |=> lgt_lat_r) else $error("light latch dropped");
  a_psel_direct:  assert property (psel_r == PSEL_A && i_particle_wr && i_particle_sel == PSEL_B |=> psel_r == PSEL_A) else $error("direct select change taken");
  a_cmd_busy:     assert property (cmd_busy |-> cmd_ms_r < T_CMD_MS) else $error("command time too long");

  c_cycle_run:    cover property (state_r == ST_CYC_UPD ##1 state_r == ST_CYC_VAL);
  c_measure_done: cover property (state_r == ST_MEASURE ##1 state_r == ST_STANDBY);
  c_sound_latch:  cover property ($rose(o_sound_alert_out_oe) ##[1:50] $fell(o_sound_alert_out_oe));
  c_back_standby: cover property (state_r == ST_TO_STBY ##1 state_r == ST_STANDBY);
endmodule

/* File: srt_pulse_src.sv */
`timescale 1ns/1ps
module srt_pulse_src (
  input  wire logic       i_go,
  input  wire logic [4:0] i_count,
  output logic            o_pulse
);
  // Pin rests low between bursts, so no stray edge reaches the counter
  initial o_pulse = 1'b0;

  // Burst of 40 ns pulses every 80 ns, started 3 ns off the core edge so phase is unrelated
  always @(posedge i_go) begin
    #3;
    repeat (i_count) begin
      o_pulse = 1'b1;
      #40;
      o_pulse = 1'b0;
      #40;
    end
  end
endmodule

/* File: sensor_ready_interrupt_timing_tb.sv */
`timescale 1ns/1ps
module sensor_ready_interrupt_timing_tb;
  import srt_pkg::*;
  localparam int P = 2;
  typedef struct {logic lvl; int ms;} srt_win_t;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n    = 1'b0;
  logic [6:0]  cmd        = 7'h00;
  logic [1:0]  cyc_sel    = 2'h0;
  logic [1:0]  en         = 2'h0;
  logic [1:0]  cmpt       = 2'h0;
  logic [1:0]  over       = 2'h0;
  logic        p_wr       = 1'b0;
  logic [7:0]  p_sel      = 8'h00;
  logic        go         = 1'b0;
  logic [4:0]  burst      = 5'h00;
  logic [15:0] base;
  wire         pulse, ready_oe, bus_ign, busy, cyc_mode, p_en, f_set;
  wire  [1:0]  alert;
  wire  [7:0]  sel_o;
  wire  [15:0] edges;
  int          err_total = 0;
  int          tests_run = 0;
  int          seed      = 68708;
  int          cnt       = 0;
  logic        last      = 1'b0;
  srt_win_t    q[$];
  srt_win_t    e;

  always #5 i_core_clk = ~i_core_clk;

  // Command bits: reset, measure, cycle, standby, clear sound, clear light, write start
  srt_sequencer #(.P_MS_CYCLES(P)) DUT (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cmd_reset(cmd[0]), .i_cmd_measure(cmd[1]),
    .i_cmd_cycle(cmd[2]), .i_cmd_standby(cmd[3]), .i_cmd_clr_sound(cmd[4]), .i_cmd_clr_light(cmd[5]),
    .i_wr_start(cmd[6]), .i_cycle_sel(cyc_sel), .i_particle_wr(p_wr), .i_particle_sel(p_sel),
    .i_sound_en(en[0]), .i_sound_cmp(cmpt[0]), .i_sound_over(over[0]),
    .i_light_en(en[1]), .i_light_cmp(cmpt[1]), .i_light_over(over[1]),
    .i_particle_pulse_in(pulse), .o_ready_oe(ready_oe), .o_sound_alert_out_oe(alert[0]),
    .o_light_alert_out_oe(alert[1]), .o_bus_ignore(bus_ign), .o_cmd_busy(busy),
    .o_cycle_mode(cyc_mode), .o_particle_sel(sel_o), .o_particle_en(p_en),
    .o_filter_settled(f_set), .o_particle_edges(edges)
  );

  srt_pulse_src u_src (.i_go(go), .i_count(burst), .o_pulse(pulse));

  task automatic give_verdict();
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // Zero ms marks a period whose length the bench does not bound
  task automatic check_win(input logic lvl, input int n, input srt_win_t w);
    tests_run++;
    if (w.lvl !== lvl || (w.ms > 0 && (n > w.ms * P + 6 || n < (w.ms - 1) * P))) begin
      err_total++;
      $display("BAD %0t ready level %0d lasted %0d cycles", $time, lvl, n);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic note(input logic l, input int ms);
    q.push_back('{l, ms});
  endtask

  task automatic send(input int b);
    @(posedge i_core_clk) cmd <= 7'h01 << b;
    @(posedge i_core_clk) cmd <= 7'h00;
  endtask

  task automatic wait_rdy(input logic l, input int max);
    int k;
    k = 0;
    while (ready_oe !== l && k < max) begin
      @(posedge i_core_clk);
      k++;
    end
    check_bit(ready_oe, l, "ready wait timed out");
  endtask

  task automatic psel(input logic [7:0] v);
    @(posedge i_core_clk) begin
      p_wr  <= 1'b1;
      p_sel <= v;
    end
    @(posedge i_core_clk) p_wr <= 1'b0;
    wait_cyc(6 * P + 1);
  endtask

  // Comparator then latch on both alert lines, each cleared on its own
  task automatic alerts();
    @(posedge i_core_clk) begin
      en   <= 2'h3;
      cmpt <= 2'h3;
      over <= 2'h3;
    end
    wait_cyc(4);
    for (int i = 0; i < 2; i++) check_bit(alert[i], 1'b1, "alert not driven");
    @(posedge i_core_clk) over <= 2'h0;
    wait_cyc(4);
    for (int i = 0; i < 2; i++) check_bit(alert[i], 1'b0, "comparator stuck");
    @(posedge i_core_clk) begin
      cmpt <= 2'h0;
      over <= 2'h3;
    end
    @(posedge i_core_clk) over <= 2'h0;
    wait_cyc(4);
    for (int i = 0; i < 2; i++) check_bit(alert[i], 1'b1, "latch lost");
    send(4);
    wait_cyc(10 * P);
    check_bit(alert[0], 1'b0, "sound clear late");
    check_bit(alert[1], 1'b1, "light cleared by sound");
    send(5);
    wait_cyc(10 * P);
    check_bit(alert[1], 1'b0, "light clear late");
    @(posedge i_core_clk) en <= 2'h0;
  endtask

  // Every ready change closes a period, compared with the oldest note
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt = 0;
      last = 1'b0;
    end else begin
      cnt++;
      if (ready_oe !== last) begin
        if (q.size() == 0) begin
          err_total++;
          $display("BAD %0t unexpected ready change", $time);
        end else begin
          e = q.pop_front();
          check_win(last, cnt, e);
        end
        last = ready_oe;
        cnt = 0;
      end
    end
  end

  // Bound is several times the expected run length
  initial begin
    #(60000 * 10);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    wait_cyc(12);
    i_rst_n <= 1'b1;
    note(1'b0, 260);
    wait_rdy(1'b1, 260 * P + 40);
    check_bit(p_en, 1'b0, "particle on after power-up");
    check_bit(bus_ign, 1'b0, "bus ignored in standby");
    alerts();
    // Two back-to-back write starts, busy must end within 6 ms of the second
    @(posedge i_core_clk) cmd <= 7'h40;
    wait_cyc(2);
    cmd <= 7'h00;
    wait_cyc(1);
    check_bit(busy, 1'b1, "write not busy");
    for (int k = 0; k < 6 * P + 4 && busy === 1'b1; k++) @(posedge i_core_clk);
    check_bit(busy, 1'b0, "write too long");
    // Particle select: direct 1 to 2 and other values are ignored
    psel(PSEL_A);
    check_bit(p_en, 1'b1, "select 1 refused");
    check_bit(f_set, 1'b0, "filter settled at once");
    psel(PSEL_B);
    check_bit(sel_o === PSEL_A, 1'b1, "direct change taken");
    base = edges;
    @(posedge i_core_clk) begin
      burst <= 5'h01 + 5'($random(seed) & 15);
      go    <= 1'b1;
    end
    wait_cyc(2);
    go <= 1'b0;
    wait_cyc(burst * 8 + 20);
    check_bit(edges === base + 16'(burst), 1'b1, "pulse count");
    psel(PSEL_OFF);
    check_bit(p_en, 1'b0, "select 0 refused");
    psel(8'h03 + 8'({$random(seed)} % 253));
    check_bit(p_en, 1'b0, "odd select taken");
    psel(PSEL_B);
    check_bit(sel_o === PSEL_B, 1'b1, "select 2 refused");
    // Measurement with a cycle command that must be dropped
    note(1'b1, 0);
    note(1'b0, 505);
    send(1);
    wait_rdy(1'b0, 10);
    check_bit(bus_ign, 1'b1, "bus live in measure");
    send(2);
    wait_rdy(1'b1, 505 * P + 20);
    check_bit(cyc_mode, 1'b0, "command taken in measure");
    // Short cycle: entry, one full valid and update, then standby
    note(1'b1, 0);
    note(1'b0, 600);
    note(1'b1, 2950);
    note(1'b0, 55);
    note(1'b1, 0);
    note(1'b0, 11);
    send(2);
    wait_rdy(1'b0, 10);
    wait_rdy(1'b1, 600 * P + 20);
    check_bit(cyc_mode, 1'b1, "no cycle mode");
    wait_rdy(1'b0, 2950 * P + 20);
    wait_rdy(1'b1, 55 * P + 20);
    alerts();
    send(3);
    wait_rdy(1'b0, 10);
    wait_rdy(1'b1, 11 * P + 20);
    check_bit(cyc_mode, 1'b0, "standby not entered");
    // Long periods: only the entry and standby return times are bounded here
    for (int s = 1; s < 3; s++) begin
      @(posedge i_core_clk) cyc_sel <= 2'(s);
      note(1'b1, 0);
      note(1'b0, 2600);
      note(1'b1, 0);
      note(1'b0, 11);
      send(2);
      wait_rdy(1'b0, 10);
      wait_rdy(1'b1, 2600 * P + 20);
      send(3);
      wait_rdy(1'b0, 10);
      wait_rdy(1'b1, 11 * P + 20);
    end
    // Reset command restarts init and drops the particle select
    note(1'b1, 0);
    note(1'b0, 260);
    send(0);
    wait_rdy(1'b0, 10);
    wait_rdy(1'b1, 260 * P + 20);
    check_bit(p_en, 1'b0, "particle kept after reset");
    give_verdict();
  end
endmodule
